/* pms_top.sv */
`default_nettype none
// Operation
// R01: Entering serial mode switches regulator to the serial-mode level field.
// R02: In serial mode, line state is not presented on data bits 0 and 1.
// R03: Weak pull-ups off while reset pin low, else follow their own bits.
// R04: Audio switches open in normal use; carkit enable bits reset disabled.
// R05: Reset pin low or core supply absent closes both audio switches.
// R06: Otherwise plus switch follows left bit, minus follows right OR mic.
// R07: Single-ended receivers are disabled while either audio switch is on.
// R08: A strap tied high reads one, tied low reads zero.
// R09: Strap code selects one of eight reference frequencies.
// R10: Input-clock mode forces a fixed 60 MHz reference.
// R11: Report received packet end within 43 bit clocks of its line end.
// R12: Link takes bus direction only from the direction output.
// R13: Decoder routes link bytes to transmitter or register array.
// R14: Straps sampled during reset, decoded frequency held until next reset.
module pms_top (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic [pms_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [pms_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [pms_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        active_low_reset_pin,
    input  wire logic                        core_supply_present,
    input  wire logic [2:0]                  ref_freq_strap_pins,
    input  wire logic                        input_clock_mode_pin,
    input  wire logic [1:0]                  line_state_in,
    input  wire logic                        rx_line_end,
    input  wire logic                        phy_has_data,
    input  wire logic [7:0]                  link_byte,
    output logic                             charger_weak_pullup_plus_en,
    output logic                             charger_weak_pullup_minus_en,
    output logic                             plus_switch_en,
    output logic                             minus_switch_en,
    output logic                             se_receiver_en,
    output logic      [1:0]                  regulator_level,
    output logic      [1:0]                  data_low_bits,
    output logic                             receive_end,
    output logic                             bus_dir,
    output logic                             to_transmitter,
    output logic                             to_register_array,
    output logic      [pms_pkg::FREQ_W-1:0]  ref_freq_khz
);
    // Two-flop synchronisers for the asynchronous pins
    logic       rstpin_m_r, rstpin_s_r;
    logic       supply_m_r, supply_s_r;
    logic [2:0] strap_m_r,  strap_s_r;
    logic       inclk_m_r,  inclk_s_r;
    logic [1:0] lstate_m_r, lstate_s_r;

    always_ff @(posedge mclk) begin
        rstpin_m_r <= active_low_reset_pin;
        rstpin_s_r <= rstpin_m_r;
        supply_m_r <= core_supply_present;
        supply_s_r <= supply_m_r;
        strap_m_r  <= ref_freq_strap_pins; // R08
        strap_s_r  <= strap_m_r;
        inclk_m_r  <= input_clock_mode_pin;
        inclk_s_r  <= inclk_m_r;
        lstate_m_r <= line_state_in;
        lstate_s_r <= lstate_m_r;
    end

    // Straps are caught every cycle of reset; last value before release wins
    logic [2:0] strap_code_r;
    logic       inclk_mode_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            strap_code_r <= strap_s_r; // R14
            inclk_mode_r <= inclk_s_r;
        end
    end

    pms_strap_decode u_strap (
        .mclk             (mclk),
        .rst              (rst),
        .strap_code       (strap_code_r),
        .input_clock_mode (inclk_mode_r),
        .ref_freq_khz     (ref_freq_khz)
    );

    // Control registers
    logic       pullup_plus_r, pullup_minus_r;
    logic [1:0] ser_lvl_r, norm_lvl_r;
    logic       serial_mode_r;
    logic       spk_left_r, spk_right_r, mic_r;
    logic [7:0] tx_cnt_r, reg_cnt_r;

    function automatic logic hit(input logic [pms_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    always_ff @(posedge mclk) begin
        if (rst) begin
            pullup_plus_r  <= 1'b0;
            pullup_minus_r <= 1'b0;
            ser_lvl_r      <= pms_pkg::SER_LVL_RST;
            norm_lvl_r     <= pms_pkg::NORM_LVL_RST;
            serial_mode_r  <= 1'b0;
        end else if (reg_wr && hit(reg_addr, pms_pkg::REG_IO_POWER)) begin
            pullup_plus_r  <= reg_wdata[pms_pkg::IOP_PULLUP_PLUS];
            pullup_minus_r <= reg_wdata[pms_pkg::IOP_PULLUP_MINUS];
            ser_lvl_r      <= reg_wdata[pms_pkg::IOP_SER_LVL_LO +: pms_pkg::LVL_W];
            norm_lvl_r     <= reg_wdata[pms_pkg::IOP_NORM_LVL_LO +: pms_pkg::LVL_W];
            serial_mode_r  <= reg_wdata[pms_pkg::IOP_SERIAL_MODE];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            spk_left_r  <= 1'b0; // R04
            spk_right_r <= 1'b0;
            mic_r       <= 1'b0;
        end else if (reg_wr && hit(reg_addr, pms_pkg::REG_CARKIT)) begin
            spk_left_r  <= reg_wdata[pms_pkg::CK_SPK_LEFT];
            spk_right_r <= reg_wdata[pms_pkg::CK_SPK_RIGHT];
            mic_r       <= reg_wdata[pms_pkg::CK_MIC];
        end
    end

    // Pin-level switch and pull-up logic
    logic pullup_plus_nxt, pullup_minus_nxt;
    logic sw_plus_nxt, sw_minus_nxt;
    logic forced_on;

    always_comb begin
        // Switches fail closed so audio passes with the core unpowered
        forced_on        = !rstpin_s_r || !supply_s_r; // R05
        pullup_plus_nxt  = rstpin_s_r && pullup_plus_r; // R03
        pullup_minus_nxt = rstpin_s_r && pullup_minus_r;
        sw_plus_nxt      = forced_on || spk_left_r; // R06
        sw_minus_nxt     = forced_on || spk_right_r || mic_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            charger_weak_pullup_plus_en  <= 1'b0;
            charger_weak_pullup_minus_en <= 1'b0;
        end else begin
            charger_weak_pullup_plus_en  <= pullup_plus_nxt;
            charger_weak_pullup_minus_en <= pullup_minus_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            plus_switch_en  <= 1'b0;
            minus_switch_en <= 1'b0;
            se_receiver_en  <= 1'b1;
        end else begin
            plus_switch_en  <= sw_plus_nxt;
            minus_switch_en <= sw_minus_nxt;
            se_receiver_en  <= !(sw_plus_nxt || sw_minus_nxt); // R07
        end
    end

    // Regulator level and line state presentation
    always_ff @(posedge mclk) begin
        if (rst) begin
            regulator_level <= pms_pkg::NORM_LVL_RST;
            data_low_bits   <= 2'h0;
        end else begin
            regulator_level <= serial_mode_r ? ser_lvl_r : norm_lvl_r; // R01
            data_low_bits   <= serial_mode_r ? 2'h0 : lstate_s_r; // R02
        end
    end

    // Packet end report; counted in mclk, rounded down to stay under 43 bit times
    logic [pms_pkg::RX_CNT_W-1:0] rx_cnt_r;
    logic                         rx_busy_r;
    // Acceptance and output flops cost one cycle each out of the budget
    localparam int RX_DLY = pms_pkg::RX_END_CYC;
    localparam logic [pms_pkg::RX_CNT_W-1:0] RX_LAST =
        pms_pkg::RX_CNT_W'(RX_DLY - 2);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_cnt_r    <= '0;
            rx_busy_r   <= 1'b0;
            receive_end <= 1'b0;
        end else begin
            receive_end <= 1'b0;
            if (rx_busy_r) begin
                if (rx_cnt_r == RX_LAST) begin
                    rx_busy_r   <= 1'b0;
                    receive_end <= 1'b1; // R11
                end else begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                end
            end else if (rx_line_end) begin
                rx_busy_r <= 1'b1;
                rx_cnt_r  <= '0;
            end
        end
    end

    // Direction and command routing
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_dir <= 1'b1;
        end else begin
            bus_dir <= phy_has_data; // R12
        end
    end

    logic [1:0] cmd_type;
    logic       link_cmd;
    logic       dir_prev_r;
    assign cmd_type = link_byte[pms_pkg::CMD_TYPE_HI:pms_pkg::CMD_TYPE_LO];
    // Turn-around cycle after a direction change is never decoded
    assign link_cmd = !bus_dir && !dir_prev_r && (link_byte != pms_pkg::CMD_IDLE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            dir_prev_r        <= 1'b1;
            to_transmitter    <= 1'b0;
            to_register_array <= 1'b0;
        end else begin
            dir_prev_r        <= bus_dir;
            to_transmitter    <= link_cmd && (cmd_type == pms_pkg::CMD_TRANSMIT); // R13
            to_register_array <= link_cmd && cmd_type[1];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_cnt_r  <= 8'h00;
            reg_cnt_r <= 8'h00;
        end else begin
            if (to_transmitter) begin
                tx_cnt_r <= tx_cnt_r + 8'h01;
            end
            if (to_register_array) begin
                reg_cnt_r <= reg_cnt_r + 8'h01;
            end
        end
    end

    // Read port
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            case (reg_addr)
                pms_pkg::REG_IO_POWER: begin
                    reg_rdata[pms_pkg::IOP_PULLUP_PLUS]  <= pullup_plus_r;
                    reg_rdata[pms_pkg::IOP_PULLUP_MINUS] <= pullup_minus_r;
                    reg_rdata[pms_pkg::IOP_SER_LVL_LO +: pms_pkg::LVL_W]  <= ser_lvl_r;
                    reg_rdata[pms_pkg::IOP_SERIAL_MODE]  <= serial_mode_r;
                    reg_rdata[pms_pkg::IOP_NORM_LVL_LO +: pms_pkg::LVL_W] <= norm_lvl_r;
                end
                pms_pkg::REG_CARKIT: begin
                    reg_rdata[pms_pkg::CK_SPK_LEFT]  <= spk_left_r;
                    reg_rdata[pms_pkg::CK_SPK_RIGHT] <= spk_right_r;
                    reg_rdata[pms_pkg::CK_MIC]       <= mic_r;
                end
                pms_pkg::REG_STATUS: begin
                    reg_rdata[pms_pkg::ST_SW_PLUS]    <= plus_switch_en;
                    reg_rdata[pms_pkg::ST_SW_MINUS]   <= minus_switch_en;
                    reg_rdata[pms_pkg::ST_SE_RX_ON]   <= se_receiver_en;
                    reg_rdata[pms_pkg::ST_SERIAL]     <= serial_mode_r;
                    reg_rdata[pms_pkg::ST_STRAP_LO +: pms_pkg::STRAP_W] <= strap_code_r;
                    reg_rdata[pms_pkg::ST_INCLK_MODE] <= inclk_mode_r;
                end
                pms_pkg::REG_REF_FREQ: begin
                    reg_rdata[pms_pkg::FREQ_W-1:0] <= ref_freq_khz;
                end
                pms_pkg::REG_CMD_CNT: begin
                    reg_rdata[15:0] <= {reg_cnt_r, tx_cnt_r};
                end
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_line_end;
        rx_line_end && !rx_busy_r;
    endsequence
    sequence s_report;
        ##RX_DLY receive_end;
    endsequence

    chk_serial_regulator: assert property ( // R01
        serial_mode_r |=> regulator_level == $past(ser_lvl_r))
        else $error("regulator not at serial level");
    chk_serial_linestate: assert property ( // R02
        serial_mode_r |=> data_low_bits == 2'h0)
        else $error("line state shown in serial mode");
    chk_pullup_gating: assert property ( // R03
        !rstpin_s_r |=> !charger_weak_pullup_plus_en && !charger_weak_pullup_minus_en)
        else $error("pull-up on while reset pin low");
    chk_switch_forced: assert property ( // R05
        (!rstpin_s_r || !supply_s_r) |=> plus_switch_en && minus_switch_en)
        else $error("switches not forced closed");
    chk_switch_follow: assert property ( // R06
        (rstpin_s_r && supply_s_r) |=>
            plus_switch_en == $past(spk_left_r) &&
            minus_switch_en == ($past(spk_right_r) || $past(mic_r)))
        else $error("switch does not follow carkit bits");
    chk_se_rx_off: assert property ( // R07
        se_receiver_en == !(plus_switch_en || minus_switch_en))
        else $error("single-ended receiver on with switch on");
    chk_freq_60m: assert property ( // R10
        inclk_mode_r && !$rose(rst) |-> ##1 ref_freq_khz == pms_pkg::FREQ_60M)
        else $error("input clock mode not 60 MHz");
    chk_strap_hold: assert property ( // R14
        !rst && !$past(rst) |-> $stable(strap_code_r) && $stable(inclk_mode_r))
        else $error("strap code changed outside reset");
    chk_rx_end_time: assert property ( // R11
        s_line_end |-> s_report)
        else $error("receive end not reported in time");
    chk_rx_end_bound: assert property ( // R11
        rx_busy_r |-> rx_cnt_r <= RX_LAST)
        else $error("receive end latency exceeds bound");
    chk_cmd_route: assert property ( // R13
        link_cmd |=> to_transmitter != to_register_array || $past(cmd_type) == 2'h0)
        else $error("command routed to both paths");
endmodule
`default_nettype wire

/* pms_pkg.sv */
`default_nettype none
package pms_pkg;
    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] REG_IO_POWER = 8'h00;
    localparam logic [7:0] REG_CARKIT   = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_REF_FREQ = 8'h0C;
    localparam logic [7:0] REG_CMD_CNT  = 8'h10;

    // IO and power management fields
    localparam int IOP_PULLUP_PLUS  = 0;
    localparam int IOP_PULLUP_MINUS = 1;
    localparam int IOP_SER_LVL_LO   = 2;
    localparam int IOP_SERIAL_MODE  = 4;
    localparam int IOP_NORM_LVL_LO  = 5;
    localparam int LVL_W            = 2;
    localparam logic [1:0] SER_LVL_RST  = 2'h0;
    localparam logic [1:0] NORM_LVL_RST = 2'h0;

    // Carkit control fields
    localparam int CK_SPK_LEFT  = 0;
    localparam int CK_SPK_RIGHT = 1;
    localparam int CK_MIC       = 2;

    // Status fields
    localparam int ST_SW_PLUS    = 0;
    localparam int ST_SW_MINUS   = 1;
    localparam int ST_SE_RX_ON   = 2;
    localparam int ST_SERIAL     = 3;
    localparam int ST_STRAP_LO   = 4;
    localparam int ST_INCLK_MODE = 7;

    // Reference frequencies in kHz
    localparam int FREQ_W = 16;
    localparam logic [15:0] FREQ_52M   = 16'hCB20;
    localparam logic [15:0] FREQ_38M4  = 16'h9600;
    localparam logic [15:0] FREQ_12M   = 16'h2EE0;
    localparam logic [15:0] FREQ_27M   = 16'h6978;
    localparam logic [15:0] FREQ_13M   = 16'h32C8;
    localparam logic [15:0] FREQ_19M2  = 16'h4B00;
    localparam logic [15:0] FREQ_26M   = 16'h6590;
    localparam logic [15:0] FREQ_24M   = 16'h5DC0;
    localparam logic [15:0] FREQ_60M   = 16'hEA60;
    localparam int STRAP_W = 3;

    // Receive end latency
    localparam int MCLK_KHZ         = 125000;
    localparam int HS_BIT_KHZ       = 480000;
    localparam int RX_END_BITS      = 43;
    localparam int RX_END_LIMIT     = 63;
    localparam int RX_END_CYC       = (RX_END_BITS * MCLK_KHZ) / HS_BIT_KHZ;
    localparam int RX_CNT_W         = 4;

    // Link command byte type field
    localparam int CMD_TYPE_HI = 7;
    localparam int CMD_TYPE_LO = 6;
    localparam logic [1:0] CMD_TRANSMIT = 2'h1;
    localparam logic [7:0] CMD_IDLE     = 8'h00;
endpackage
`default_nettype wire

/* pms_strap_decode.sv */
`default_nettype none
module pms_strap_decode (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic [pms_pkg::STRAP_W-1:0]  strap_code,
    input  wire logic                         input_clock_mode,
    output logic      [pms_pkg::FREQ_W-1:0]   ref_freq_khz
);
    function automatic logic [pms_pkg::FREQ_W-1:0] decode_freq(
        input logic [pms_pkg::STRAP_W-1:0] code,
        input logic                        inclk
    );
        logic [pms_pkg::FREQ_W-1:0] f;
        f = pms_pkg::FREQ_52M;
        case (code)
            3'h0: f = pms_pkg::FREQ_52M; // R09
            3'h1: f = pms_pkg::FREQ_38M4;
            3'h2: f = pms_pkg::FREQ_12M;
            3'h3: f = pms_pkg::FREQ_27M;
            3'h4: f = pms_pkg::FREQ_13M;
            3'h5: f = pms_pkg::FREQ_19M2;
            3'h6: f = pms_pkg::FREQ_26M;
            3'h7: f = pms_pkg::FREQ_24M;
            default: f = pms_pkg::FREQ_52M;
        endcase
        // Link-sourced clock overrides the straps
        if (inclk) begin
            f = pms_pkg::FREQ_60M; // R10
        end
        return f;
    endfunction

    always_ff @(posedge mclk) begin
        ref_freq_khz <= decode_freq(strap_code, input_clock_mode);
    end
endmodule
`default_nettype wire

/* pms_link_model.sv */
`default_nettype none
module pms_link_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       bus_dir,
    input  wire logic [7:0] cmd_byte,
    input  wire logic       cmd_go,
    output logic      [7:0] link_byte,
    output logic            cmd_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cmd_q;

    // Released bus toggles every cycle so a stale byte never looks valid
    // Drives again right after the turn-around cycle, when the decoder first looks
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_busy  <= 1'b0;
            link_byte <= 8'h00;
        end else begin
            if (cmd_go) begin
                cmd_busy <= 1'b1;
                cmd_q    <= cmd_byte;
            end
            if (bus_dir) begin
                link_byte <= ~link_byte;
            end else if (cmd_busy) begin
                link_byte <= cmd_q;
                cmd_busy  <= 1'b0;
            end else begin
                link_byte <= pms_pkg::CMD_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

/* pms_top_tb.sv */
`default_nettype none
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin n_fail++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module pms_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, rst, reg_wr, reg_rd, rx_line_end, phy_has_data, cmd_go, cmd_busy;
    logic        active_low_reset_pin, core_supply_present, input_clock_mode_pin;
    logic [7:0]  reg_addr, link_byte, cmd_byte;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [2:0]  ref_freq_strap_pins;
    logic [1:0]  line_state_in, regulator_level, data_low_bits;
    logic        pu_plus, pu_minus, sw_plus, sw_minus, se_rx, receive_end, bus_dir;
    logic        to_transmitter, to_register_array;
    logic [15:0] ref_freq_khz;
    int          n_fail, n_compared, n_tx, n_rg, n_rxe;
    time         t0, t_rxe;
    logic [15:0] ftab [8] = '{pms_pkg::FREQ_52M, pms_pkg::FREQ_38M4, pms_pkg::FREQ_12M,
        pms_pkg::FREQ_27M, pms_pkg::FREQ_13M, pms_pkg::FREQ_19M2, pms_pkg::FREQ_26M,
        pms_pkg::FREQ_24M};
    logic [7:0]  ctab [4] = '{8'h41, 8'h8A, 8'hC3, 8'h05};

    pms_top dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .active_low_reset_pin(active_low_reset_pin), .core_supply_present(core_supply_present),
        .ref_freq_strap_pins(ref_freq_strap_pins), .input_clock_mode_pin(input_clock_mode_pin),
        .line_state_in(line_state_in), .rx_line_end(rx_line_end), .phy_has_data(phy_has_data),
        .link_byte(link_byte), .charger_weak_pullup_plus_en(pu_plus),
        .charger_weak_pullup_minus_en(pu_minus), .plus_switch_en(sw_plus),
        .minus_switch_en(sw_minus), .se_receiver_en(se_rx), .regulator_level(regulator_level),
        .data_low_bits(data_low_bits), .receive_end(receive_end), .bus_dir(bus_dir),
        .to_transmitter(to_transmitter), .to_register_array(to_register_array),
        .ref_freq_khz(ref_freq_khz));

    pms_link_model link_u (.mclk(mclk), .rst(rst), .bus_dir(bus_dir), .cmd_byte(cmd_byte),
        .cmd_go(cmd_go), .link_byte(link_byte), .cmd_busy(cmd_busy));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (to_transmitter === 1'b1) n_tx++;
        if (to_register_array === 1'b1) n_rg++;
        if (receive_end === 1'b1) begin
            n_rxe++;
            t_rxe = $time;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic send_cmd(input logic [7:0] b);
        @(posedge mclk);
        cmd_byte <= b;
        cmd_go   <= 1'b1;
        @(posedge mclk);
        cmd_go <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 60 && cmd_busy !== 1'b0; i++) @(posedge mclk);
        `CHK(cmd_busy, 1'b0)
        cyc(3);
    endtask

    task automatic reset_dut();
        @(posedge mclk);
        rst <= 1'b1;
        cyc(10);
        rst <= 1'b0;
        cyc(5);
    endtask

    task automatic complete_run();
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #300000;
        n_fail++;
        complete_run();
    end

    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
        active_low_reset_pin = 1'b1; core_supply_present = 1'b1; input_clock_mode_pin = 1'b0;
        ref_freq_strap_pins = 3'h7; line_state_in = 2'h0; rx_line_end = 1'b0;
        phy_has_data = 1'b0; cmd_byte = 8'h00; cmd_go = 1'b0;
        reset_dut();
        rdr(pms_pkg::REG_CARKIT, rd); `CHK(rd, 32'h0)
        rdr(pms_pkg::REG_IO_POWER, rd); `CHK(rd, 32'h0)
        `CHK({sw_plus, sw_minus, se_rx}, 3'h1)
        rdr(8'h40, rd); `CHK(rd, 32'h0)
        wr(pms_pkg::REG_REF_FREQ, 32'hFFFF);
        rdr(pms_pkg::REG_REF_FREQ, rd); `CHK(rd[15:0], pms_pkg::FREQ_24M)
        wr(pms_pkg::REG_IO_POWER, 32'h1); cyc(3); `CHK({pu_plus, pu_minus}, 2'h2)
        wr(pms_pkg::REG_IO_POWER, 32'h2); cyc(3); `CHK({pu_plus, pu_minus}, 2'h1)
        wr(pms_pkg::REG_IO_POWER, 32'h3);
        active_low_reset_pin <= 1'b0;
        cyc(5);
        `CHK({pu_plus, pu_minus}, 2'h0)
        `CHK({sw_plus, sw_minus}, 2'h3)
        `CHK(se_rx, 1'b0)
        active_low_reset_pin <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(pms_pkg::REG_CARKIT, k); cyc(5);
            `CHK({sw_plus, sw_minus}, {k[0], k[1] | k[2]})
            `CHK(se_rx, ~(k[0] | k[1] | k[2]))
            rdr(pms_pkg::REG_STATUS, rd); `CHK(rd[1:0], {k[1] | k[2], k[0]})
        end
        wr(pms_pkg::REG_CARKIT, 32'h0);
        core_supply_present <= 1'b0;
        cyc(5);
        `CHK({sw_plus, sw_minus, se_rx}, 3'h6)
        core_supply_present <= 1'b1;
        line_state_in <= 2'h2;
        wr(pms_pkg::REG_IO_POWER, 32'h28); cyc(5);
        `CHK(regulator_level, 2'h1)
        `CHK(data_low_bits, 2'h2)
        wr(pms_pkg::REG_IO_POWER, 32'h38); cyc(3);
        `CHK(regulator_level, 2'h2)
        `CHK(data_low_bits, 2'h0)
        rdr(pms_pkg::REG_STATUS, rd); `CHK(rd[3], 1'b1)
        n_rxe = 0;
        @(posedge mclk) rx_line_end <= 1'b1;
        @(posedge mclk) rx_line_end <= 1'b0;
        t0 = $time;
        cyc(2);
        rx_line_end <= 1'b1;
        @(posedge mclk) rx_line_end <= 1'b0;
        cyc(30);
        `CHK(n_rxe, 1)
        `CHK((t_rxe - t0) / 8, pms_pkg::RX_END_CYC)
        for (int i = 0; i < 4; i++) send_cmd(ctab[i]);
        `CHK(n_tx, 1)
        `CHK(n_rg, 2)
        rdr(pms_pkg::REG_CMD_CNT, rd); `CHK(rd[15:0], 16'h0201)
        phy_has_data <= 1'b1;
        cyc(3);
        `CHK(bus_dir, 1'b1)
        @(posedge mclk) cmd_byte <= 8'h42;
        cmd_go <= 1'b1;
        @(posedge mclk) cmd_go <= 1'b0;
        cyc(10);
        `CHK(n_tx, 1)
        phy_has_data <= 1'b0;
        cyc(10);
        `CHK(n_tx, 2)
        for (int c = 0; c < 8; c++) begin
            @(posedge mclk) ref_freq_strap_pins <= c[2:0];
            reset_dut();
            `CHK(ref_freq_khz, ftab[c])
            rdr(pms_pkg::REG_STATUS, rd); `CHK(rd[6:4], c[2:0])
        end
        ref_freq_strap_pins <= 3'h0;
        cyc(8);
        `CHK(ref_freq_khz, pms_pkg::FREQ_24M)
        input_clock_mode_pin <= 1'b1;
        reset_dut();
        `CHK(ref_freq_khz, pms_pkg::FREQ_60M)
        rdr(pms_pkg::REG_REF_FREQ, rd); `CHK(rd[15:0], pms_pkg::FREQ_60M)
        rdr(pms_pkg::REG_STATUS, rd); `CHK(rd[7], 1'b1)
        complete_run();
    end
endmodule
`default_nettype wire
